// ==== lkm_lock_match.sv ====
// keypad lock, unlock, interrupt mask and reset event matching
//
// Functional notes
// - Holds first unlock code; its event starts unlocking once locking is enabled.
// - Holds second unlock code; seen after the first, it unlocks the keypad.
// - Bit 7 of the second unlock register selects press for key events.
// - State bit 1 matches active, 0 inactive transitions of fifo events.
// - Lock code event locks the keypad and sets the lock flag.
// - Bit 7 of the lock event register selects the matched state.
// - Locked with mask time set: one event interrupts, then mask starts.
// - While the mask runs no event interrupts, until expiry or unlock.
// - Unlock window 1 to 7 seconds after first unlock event; 0 disables.
// - Window timeout or any other event returns keypad to full lock.
// - Lock configuration bit 0 enables locking; bits 7 to 1 reserved.
// - Reset event codes qualify the primary reset output.
// - A reset code register holding zero takes no part.
// - Reset fires only when all enabled reset events are held together.
// - Bit 7 of first reset register selects press or active level.
// - Second reset register holds another code and level, same meaning.
`timescale 1ns/10ps
`default_nettype none

module lkm_lock_match
#(
    parameter int unsigned P_SEC_CYCLES = lkm_pkg::SEC_CYCLES
)(
    input  wire logic               i_clk_sys,     // 50 MHz clock
    input  wire logic               i_reset_n,     // sync reset, low
    input  wire logic               i_reg_wr,      // register write strobe
    input  wire logic [7:0]         i_reg_addr,    // register offset
    input  wire logic [7:0]         i_reg_wdata,   // register write data
    output logic      [7:0]         o_reg_rdata,   // registered read data
    input  wire logic               i_evt_valid,   // event logged pulse
    input  wire lkm_pkg::lkm_code_t i_evt_code,    // event identifier
    input  wire logic               i_evt_state,   // 1 press or active
    input  wire logic               i_lock_int_clr,// clear lock flag
    output logic                    o_evt_int,     // event interrupt pulse
    output logic                    o_lock_int,    // sticky lock flag
    output logic                    o_locked,      // keypad locked
    output logic                    o_primary_reset_output // reset request
);
    import lkm_pkg::*;

    typedef struct packed {
        lkm_evreg_s first_unlock_code;
        lkm_evreg_s second_unlock_code;
        lkm_evreg_s lock_trigger_code;
        logic [7:0] timing;
        logic       lock_en;
        lkm_evreg_s primary_reset_code_one;
        lkm_evreg_s primary_reset_code_two;
        lkm_lock_e  lock_st;
        logic       locked;
        logic       lock_int;
        logic       evt_int;
        logic       rst_out;
        logic [7:0] rdata;
    } lkm_state_s;

    lkm_state_s st_reg;
    lkm_state_s st_next;

    lkm_evt_if evt ();
    lkm_tmr_if mask_tmr ();
    lkm_tmr_if unl_tmr ();

    logic       held_one;
    logic       held_two;
    logic       m_lock;
    logic       m_first;
    logic       m_second;
    logic       gate_open;
    logic [4:0] mask_secs;
    logic [2:0] unl_secs;
    logic       rst_all;

    // event stream into the shared carrier
    assign evt.valid = i_evt_valid;
    assign evt.code  = i_evt_code;
    assign evt.state = i_evt_state;

    // timing fields
    assign mask_secs = st_reg.timing[MASK_LSB +: MASK_W];
    assign unl_secs  = st_reg.timing[UNLOCK_LSB +: UNLOCK_W];

    // code compares against the fifo identifiers
    assign m_lock   = lkm_match(st_reg.lock_trigger_code, i_evt_valid,
                                i_evt_code, i_evt_state);
    assign m_first  = lkm_match(st_reg.first_unlock_code, i_evt_valid,
                                i_evt_code, i_evt_state);
    assign m_second = lkm_match(st_reg.second_unlock_code, i_evt_valid,
                                i_evt_code, i_evt_state);

    // one interrupt may pass while locked when the mask is armed and idle
    assign gate_open = (mask_secs != 5'h00) && !mask_tmr.running;

    // all enabled reset slots held at once, at least one enabled
    assign rst_all = (lkm_slot_on(st_reg.primary_reset_code_one)
                      || lkm_slot_on(st_reg.primary_reset_code_two))
                     && (!lkm_slot_on(st_reg.primary_reset_code_one)
                         || held_one)
                     && (!lkm_slot_on(st_reg.primary_reset_code_two)
                         || held_two);

    lkm_sec_timer #(
        .P_SEC_CYCLES (P_SEC_CYCLES)
    ) u_mask_timer (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .tmr       (mask_tmr.tmr)
    );

    lkm_sec_timer #(
        .P_SEC_CYCLES (P_SEC_CYCLES)
    ) u_unlock_timer (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .tmr       (unl_tmr.tmr)
    );

    lkm_hold_track u_hold_one (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_cfg     (st_reg.primary_reset_code_one),
        .evt       (evt.dst),
        .o_held    (held_one)
    );

    lkm_hold_track u_hold_two (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_cfg     (st_reg.primary_reset_code_two),
        .evt       (evt.dst),
        .o_held    (held_two)
    );

    // register writes, lock sequence, mask gate and read mux
    always_comb
    begin
        st_next = st_reg;
        st_next.evt_int = 1'b0;
        mask_tmr.load = 1'b0;
        mask_tmr.secs = mask_secs;
        mask_tmr.stop = 1'b0;
        unl_tmr.load = 1'b0;
        unl_tmr.secs = {2'b00, unl_secs};
        unl_tmr.stop = 1'b0;

        // lock sequence
        unique case (st_reg.lock_st)
            LKM_OPEN:
            begin
                st_next.evt_int = i_evt_valid;
                if (st_reg.lock_en && m_lock)
                    st_next.lock_st = LKM_LOCKED;
            end
            LKM_LOCKED:
            begin
                if (i_evt_valid && gate_open)
                begin
                    st_next.evt_int = 1'b1;
                    mask_tmr.load = 1'b1;
                end
                if (m_first)
                begin
                    st_next.lock_st = LKM_HALF;
                    unl_tmr.load = 1'b1;
                end
            end
            LKM_HALF:
            begin
                if (i_evt_valid && gate_open && !m_second)
                begin
                    st_next.evt_int = 1'b1;
                    mask_tmr.load = 1'b1;
                end
                if (m_second)
                begin
                    st_next.lock_st = LKM_OPEN;
                    mask_tmr.stop = 1'b1;
                    unl_tmr.stop = 1'b1;
                end
                else if (i_evt_valid || unl_tmr.expired)
                begin
                    st_next.lock_st = LKM_LOCKED;
                    unl_tmr.stop = 1'b1;
                end
            end
        endcase

        // register writes
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                ADDR_FIRST_UNLOCK:  st_next.first_unlock_code = i_reg_wdata;
                ADDR_SECOND_UNLOCK: st_next.second_unlock_code = i_reg_wdata;
                ADDR_LOCK_EVENT:    st_next.lock_trigger_code = i_reg_wdata;
                ADDR_LOCK_TIMING:   st_next.timing = i_reg_wdata;
                ADDR_LOCK_CFG:
                    st_next.lock_en = i_reg_wdata[LOCK_EN_BIT];
                ADDR_RESET_ONE:
                    st_next.primary_reset_code_one = i_reg_wdata;
                ADDR_RESET_TWO:
                    st_next.primary_reset_code_two = i_reg_wdata;
                default: ;
            endcase
        end

        // enabling locks at once; disabling opens and stops the timers
        if (!st_reg.lock_en && st_next.lock_en)
            st_next.lock_st = LKM_LOCKED;
        if (!st_next.lock_en)
        begin
            st_next.lock_st = LKM_OPEN;
            mask_tmr.stop = 1'b1;
            unl_tmr.stop = 1'b1;
        end
        st_next.locked = (st_next.lock_st != LKM_OPEN);

        // sticky lock flag, set wins over clear
        if (i_lock_int_clr)
            st_next.lock_int = 1'b0;
        if (st_reg.lock_st == LKM_OPEN && st_reg.lock_en && m_lock)
            st_next.lock_int = 1'b1;

        st_next.rst_out = rst_all;

        // read mux, reserved bits and unmapped offsets read zero
        case (i_reg_addr)
            ADDR_FIRST_UNLOCK:  st_next.rdata = st_reg.first_unlock_code;
            ADDR_SECOND_UNLOCK: st_next.rdata = st_reg.second_unlock_code;
            ADDR_LOCK_EVENT:    st_next.rdata = st_reg.lock_trigger_code;
            ADDR_LOCK_TIMING:   st_next.rdata = st_reg.timing;
            ADDR_LOCK_CFG:      st_next.rdata = {7'h00, st_reg.lock_en};
            ADDR_RESET_ONE:
                st_next.rdata = st_reg.primary_reset_code_one;
            ADDR_RESET_TWO:
                st_next.rdata = st_reg.primary_reset_code_two;
            default:            st_next.rdata = 8'h00;
        endcase
    end

    // state register
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            st_reg <= '0;
            st_reg.first_unlock_code <= RST_EVENT_REG;
            st_reg.second_unlock_code <= RST_EVENT_REG;
            st_reg.lock_trigger_code <= RST_EVENT_REG;
            st_reg.timing <= RST_TIMING_REG;
            st_reg.lock_en <= RST_LOCK_EN;
            st_reg.primary_reset_code_one <= RST_EVENT_REG;
            st_reg.primary_reset_code_two <= RST_EVENT_REG;
            st_reg.lock_st <= LKM_OPEN;
        end
        else
            st_reg <= st_next;
    end

    // outputs straight from the state register
    assign o_reg_rdata = st_reg.rdata;
    assign o_evt_int = st_reg.evt_int;
    assign o_lock_int = st_reg.lock_int;
    assign o_locked = st_reg.locked;
    assign o_primary_reset_output = st_reg.rst_out;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    property p_lock_sets_flag;
        (st_reg.lock_st == LKM_OPEN) && st_reg.lock_en && m_lock
            && !i_reg_wr |=> o_lock_int && o_locked;
    endproperty
    a_lock_sets_flag: assert property (p_lock_sets_flag)
        else $error("lock event did not lock and flag");

    property p_first_half;
        (st_reg.lock_st == LKM_LOCKED) && m_first && !i_reg_wr
            |=> (st_reg.lock_st == LKM_HALF) && o_locked;
    endproperty
    a_first_half: assert property (p_first_half)
        else $error("first unlock event not taken");

    property p_second_open;
        (st_reg.lock_st == LKM_HALF) && m_second && !i_reg_wr
            |=> !o_locked && (st_reg.lock_st == LKM_OPEN) && !mask_tmr.running;
    endproperty
    a_second_open: assert property (p_second_open)
        else $error("second unlock event did not unlock");

    property p_other_relock;
        (st_reg.lock_st == LKM_HALF) && i_evt_valid && !m_second
            && !i_reg_wr |=> (st_reg.lock_st == LKM_LOCKED);
    endproperty
    a_other_relock: assert property (p_other_relock)
        else $error("foreign event did not relock");

    property p_timeout_relock;
        (st_reg.lock_st == LKM_HALF) && unl_tmr.expired && !i_evt_valid
            && !i_reg_wr |=> (st_reg.lock_st == LKM_LOCKED);
    endproperty
    a_timeout_relock: assert property (p_timeout_relock)
        else $error("unlock window expiry did not relock");

    property p_one_passes;
        (st_reg.lock_st == LKM_LOCKED) && i_evt_valid && gate_open
            && !i_reg_wr |=> o_evt_int && mask_tmr.running;
    endproperty
    a_one_passes: assert property (p_one_passes)
        else $error("first locked event not passed or mask idle");

    property p_mask_blocks;
        (st_reg.lock_st != LKM_OPEN) && mask_tmr.running
            |=> !o_evt_int;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("event interrupt passed while masked");

    property p_disabled_open;
        !st_reg.lock_en && !i_reg_wr |-> !o_locked [*2];
    endproperty
    a_disabled_open: assert property (p_disabled_open)
        else $error("keypad locked with lock disabled");

    property p_reset_together;
        lkm_slot_on(st_reg.primary_reset_code_one)
            && lkm_slot_on(st_reg.primary_reset_code_two)
            |=> o_primary_reset_output == $past(held_one && held_two);
    endproperty
    a_reset_together: assert property (p_reset_together)
        else $error("reset output not tied to both holds");

    property p_zero_ignored;
        !lkm_slot_on(st_reg.primary_reset_code_one) && held_two
            && lkm_slot_on(st_reg.primary_reset_code_two)
            |=> o_primary_reset_output;
    endproperty
    a_zero_ignored: assert property (p_zero_ignored)
        else $error("zero reset slot blocked the reset");

    property p_flag_sticky;
        o_lock_int && !i_lock_int_clr |=> o_lock_int;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("lock flag dropped without a clear");

    c_lock: cover property (!o_locked ##1 o_lock_int);
    c_unlock: cover property ((st_reg.lock_st == LKM_HALF) ##1 !o_locked);
    c_timeout: cover property (unl_tmr.expired);
    c_reset: cover property (o_primary_reset_output);

endmodule

`default_nettype wire

// ==== lkm_pkg.sv ====
// shared constants, types and helpers of the keypad lock and reset matcher
package lkm_pkg;

    // register offsets on the device register port
    localparam logic [7:0] ADDR_FIRST_UNLOCK  = 8'h33;
    localparam logic [7:0] ADDR_SECOND_UNLOCK = 8'h34;
    localparam logic [7:0] ADDR_LOCK_EVENT    = 8'h35;
    localparam logic [7:0] ADDR_LOCK_TIMING   = 8'h36;
    localparam logic [7:0] ADDR_LOCK_CFG      = 8'h37;
    localparam logic [7:0] ADDR_RESET_ONE     = 8'h38;
    localparam logic [7:0] ADDR_RESET_TWO     = 8'h39;

    // reset values of the registers
    localparam logic [7:0] RST_EVENT_REG  = 8'h00;
    localparam logic [7:0] RST_TIMING_REG = 8'h00;
    localparam logic       RST_LOCK_EN    = 1'b0;

    // field positions
    localparam int LOCK_EN_BIT = 0;
    localparam int MASK_LSB    = 3;
    localparam int MASK_W      = 5;
    localparam int UNLOCK_LSB  = 0;
    localparam int UNLOCK_W    = 3;

    // timer unit and the derived cycle count at 50 MHz
    localparam int unsigned TIMER_UNIT_S = 1;
    localparam int unsigned CLK_HZ       = 50000000;
    localparam int unsigned SEC_CYCLES   = TIMER_UNIT_S * CLK_HZ;
    localparam int          SUB_W        = 26;

    typedef logic [6:0] lkm_code_t;

    // event register: polarity in bit 7, code in bits 6..0
    typedef struct packed {
        logic      pol;
        lkm_code_t code;
    } lkm_evreg_s;

    typedef enum logic [1:0] {LKM_OPEN, LKM_LOCKED, LKM_HALF} lkm_lock_e;

    // an event matches a register when code and state agree, code nonzero
    function automatic logic lkm_match(input lkm_evreg_s r,
                                       input logic       valid,
                                       input lkm_code_t  code,
                                       input logic       state);
        lkm_match = valid && (r.code != 7'h00) && (r.code == code)
                    && (r.pol == state);
    endfunction

    // a reset slot takes part only when its code is nonzero
    function automatic logic lkm_slot_on(input lkm_evreg_s r);
        lkm_slot_on = (r.code != 7'h00);
    endfunction

endpackage

// ==== lkm_if.sv ====
// carriers between the matcher and its timer and hold tracker modules
`timescale 1ns/10ps
`default_nettype none

// event stream as logged to the event fifo
interface lkm_evt_if;
    logic             valid;
    lkm_pkg::lkm_code_t code;
    logic             state;
    modport src (output valid, code, state);
    modport dst (input valid, code, state);
endinterface

// control and status of one seconds timer
interface lkm_tmr_if;
    logic       load;
    logic [4:0] secs;
    logic       stop;
    logic       running;
    logic       expired;
    modport ctl (output load, secs, stop, input running, expired);
    modport tmr (input load, secs, stop, output running, expired);
endinterface

`default_nettype wire

// ==== lkm_sec_timer.sv ====
// seconds down-counter with its own cycle prescaler
`timescale 1ns/10ps
`default_nettype none

module lkm_sec_timer
    import lkm_pkg::*;
#(
    parameter int unsigned P_SEC_CYCLES = lkm_pkg::SEC_CYCLES
)(
    input  wire logic  i_clk_sys, // system clock
    input  wire logic  i_reset_n, // synchronous reset, active low
    lkm_tmr_if.tmr     tmr        // load, stop and status
);
    typedef struct packed {
        logic [SUB_W-1:0] sub;
        logic [4:0]       secs;
        logic             running;
        logic             expired;
    } lkm_tmr_s;

    lkm_tmr_s st_reg;
    lkm_tmr_s st_next;
    logic     sec_tick;

    // one-cycle enable at the end of each second of counting
    assign sec_tick = (st_reg.sub == SUB_W'(P_SEC_CYCLES - 1));

    // next state: load restarts, stop wins over counting
    always_comb
    begin
        st_next = st_reg;
        st_next.expired = 1'b0;
        if (st_reg.running)
        begin
            st_next.sub = sec_tick ? '0 : st_reg.sub + 1'b1;
            if (sec_tick)
            begin
                st_next.secs = st_reg.secs - 5'h01;
                if (st_reg.secs == 5'h01)
                begin
                    st_next.running = 1'b0;
                    st_next.expired = 1'b1;
                end
            end
        end
        if (tmr.load)
        begin
            st_next.sub = '0;
            st_next.secs = tmr.secs;
            st_next.running = (tmr.secs != 5'h00); // zero disables
            st_next.expired = 1'b0;
        end
        else if (tmr.stop)
        begin
            st_next.running = 1'b0;
            st_next.expired = 1'b0;
        end
    end

    // state register
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign tmr.running = st_reg.running;
    assign tmr.expired = st_reg.expired;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    property p_zero_disables;
        tmr.load && (tmr.secs == 5'h00) |=> !tmr.running;
    endproperty
    a_zero_disables: assert property (p_zero_disables)
        else $error("timer loaded with zero is running");

    property p_expires_on_count;
        st_reg.running && !tmr.load && !tmr.stop && sec_tick
            && (st_reg.secs == 5'h01) |=> tmr.expired && !tmr.running;
    endproperty
    a_expires_on_count: assert property (p_expires_on_count)
        else $error("timer did not expire at its last second");

endmodule

`default_nettype wire

// ==== lkm_hold_track.sv ====
// remembers whether one reset event is currently held
`timescale 1ns/10ps
`default_nettype none

module lkm_hold_track
    import lkm_pkg::*;
(
    input  wire logic         i_clk_sys, // system clock
    input  wire logic         i_reset_n, // synchronous reset, active low
    input  wire lkm_evreg_s   i_cfg,     // reset event register
    lkm_evt_if.dst            evt,       // event stream
    output logic              o_held     // event is in its level now
);
    typedef struct packed {
        logic held;
    } lkm_hold_s;

    lkm_hold_s st_reg;
    lkm_hold_s st_next;

    // a matching code sets or clears the hold by its state
    always_comb
    begin
        st_next = st_reg;
        if (!lkm_slot_on(i_cfg))
            st_next.held = 1'b0;
        else if (evt.valid && (evt.code == i_cfg.code))
            st_next.held = (evt.state == i_cfg.pol);
    end

    // state register
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign o_held = st_reg.held;

endmodule

`default_nettype wire

// ==== lkm_host_model.sv ====
// host processor model driving the lock register port
`timescale 1ns/10ps
`default_nettype none

module lkm_host_model (
    input  wire logic       i_clk_sys, // system clock
    output logic            o_wr,      // write strobe
    output logic [7:0]      o_addr,    // register offset
    output logic [7:0]      o_wdata    // write data
);
    // idle port at time zero
    initial
    begin
        o_wr = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end

    // one byte write, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk_sys);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask

    // present an offset to read
    task automatic sel(input logic [7:0] a);
        @(posedge i_clk_sys);
        o_addr <= a;
    endtask
endmodule

`default_nettype wire

// ==== keypad_lock_and_reset_event_match_bench.sv ====
// self-checking bench of the lock and reset event matcher
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
 $display("mismatch t=%0t got %h exp %h", $time, a, b); end end

module keypad_lock_and_reset_event_match_bench;
    import lkm_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       wr, vld = 1'b0, st = 1'b0, clr = 1'b0;
    logic [7:0] addr, wdata, rdata;
    lkm_code_t  code = 7'h00;
    logic       evt_int, lock_int, locked, rst_out;
    int         err_total = 0;
    int         n_compared = 0;

    // 50 MHz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    lkm_host_model i_host (.i_clk_sys(clk), .o_wr(wr), .o_addr(addr),
                           .o_wdata(wdata));

    lkm_lock_match #(.P_SEC_CYCLES(20)) i_dut (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_wr(wr),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_evt_valid(vld), .i_evt_code(code), .i_evt_state(st),
        .i_lock_int_clr(clr), .o_evt_int(evt_int), .o_lock_int(lock_int),
        .o_locked(locked), .o_primary_reset_output(rst_out));

    // one event pulse, outputs checked after its taking edge
    task automatic ev(input logic [6:0] c, input logic s);
        @(posedge clk);
        vld <= 1'b1;
        code <= c;
        st <= s;
        @(posedge clk);
        vld <= 1'b0;
        code <= ~c;
        #1;
    endtask

    // read one offset and compare
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_host.sel(a);
        @(posedge clk);
        #1;
        `CHK(rdata, e)
    endtask

    // reset values, write readback, unmapped offset
    task automatic t_regs();
        for (int a = 8'h33; a <= 8'h3a; a++)
            rd(a[7:0], 8'h00);
        i_host.wr(8'h34, 8'h86);
        rd(8'h34, 8'h86);
        i_host.wr(8'h3a, 8'h55);
        rd(8'h3a, 8'h00);
        $display("test regs done");
    endtask

    // lock, two-step unlock, window timeout, stray event
    task automatic t_lock();
        i_host.wr(8'h33, 8'h85);
        i_host.wr(8'h35, 8'h87);
        i_host.wr(8'h36, 8'h01);
        i_host.wr(8'h37, 8'hff);
        rd(8'h37, 8'h01);
        `CHK(locked, 1'b1)
        ev(7'h05, 1'b1);
        `CHK(locked, 1'b1)
        ev(7'h06, 1'b1);
        `CHK(locked, 1'b0)
        ev(7'h07, 1'b1);
        `CHK(locked, 1'b1)
        `CHK(lock_int, 1'b1)
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        `CHK(lock_int, 1'b0)
        ev(7'h05, 1'b1);
        repeat (25) @(posedge clk);
        ev(7'h06, 1'b1);
        `CHK(locked, 1'b1)
        ev(7'h05, 1'b1);
        ev(7'h09, 1'b1);
        ev(7'h06, 1'b1);
        `CHK(locked, 1'b1)
        i_host.wr(8'h37, 8'h00);
        rd(8'h37, 8'h00);
        `CHK(locked, 1'b0)
        i_host.wr(8'h37, 8'h01);
        rd(8'h37, 8'h01);
        `CHK(locked, 1'b1)
        $display("test lock done");
    endtask

    // interrupt mask of one second while locked
    task automatic t_mask();
        i_host.wr(8'h36, 8'h08);
        ev(7'h09, 1'b1);
        `CHK(evt_int, 1'b1)
        ev(7'h09, 1'b1);
        `CHK(evt_int, 1'b0)
        repeat (22) @(posedge clk);
        ev(7'h09, 1'b1);
        `CHK(evt_int, 1'b1)
        ev(7'h05, 1'b1);
        ev(7'h06, 1'b1);
        `CHK(locked, 1'b0)
        ev(7'h09, 1'b0);
        `CHK(evt_int, 1'b1)
        $display("test mask done");
    endtask

    // concurrent reset events, levels and an empty slot
    task automatic t_reset();
        i_host.wr(8'h38, 8'h8a);
        i_host.wr(8'h39, 8'h0b);
        ev(7'h0a, 1'b1);
        @(posedge clk);
        #1;
        `CHK(rst_out, 1'b0)
        ev(7'h0b, 1'b0);
        @(posedge clk);
        #1;
        `CHK(rst_out, 1'b1)
        ev(7'h0a, 1'b0);
        @(posedge clk);
        #1;
        `CHK(rst_out, 1'b0)
        i_host.wr(8'h39, 8'h00);
        ev(7'h0a, 1'b1);
        @(posedge clk);
        #1;
        `CHK(rst_out, 1'b1)
        i_host.wr(8'h38, 8'h00);
        rd(8'h38, 8'h00);
        `CHK(rst_out, 1'b0)
        i_host.wr(8'h39, 8'h0b);
        ev(7'h0b, 1'b0);
        @(posedge clk);
        #1;
        `CHK(rst_out, 1'b1)
        $display("test reset done");
    endtask

    // counts and verdict, ends the run
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_lock();
        t_mask();
        t_reset();
        print_verdict();
    end

    // watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule

`default_nettype wire
